// ===== common/pwr_wake_pkg.sv
// power-mode and wake-up controller: shared constants, types and layouts
// assumes an APB slave with 12-bit byte addresses and 32-bit data
package pwr_wake_pkg;

  // ----------------------------------------------------------------------
  // register map: printed offsets are indices, byte address = 4 * index
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] PWR_CTRL_IDX = 10'h087;
  localparam logic [9:0] SETTLE_SEL_IDX = 10'h08f;
  localparam logic [9:0] WAKE_MASK_IDX = 10'h09f;
  localparam logic [9:0] IRQ_STATUS_IDX = 10'h0f0;
  localparam logic [9:0] IRQ_MASK_IDX = 10'h0f1;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned PCTL_IDLE_BIT = 0;
  localparam int unsigned PCTL_STOP_BIT = 1;
  localparam int unsigned PCTL_SLEEP_BIT = 2;
  localparam logic [2:0] PCTL_RST = 3'h0;
  localparam int unsigned SETTLE_SEL_LSB = 2;
  localparam logic [1:0] SETTLE_SEL_RST = 2'h2;
  localparam logic [7:0] WAKE_MASK_RST = 8'hff;
  localparam logic [7:0] PIN_ACTIVE_LOW = 8'h03;
  localparam logic [7:0] WAKE_LINE_IMPL = 8'hdf;
  localparam int unsigned ST_IDLE_WAKE = 0;
  localparam int unsigned ST_STOP_WAKE = 1;
  localparam int unsigned ST_SLEEP_WAKE = 2;
  localparam int unsigned ST_SETTLED = 3;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------------
  // timing: regulator settle in oscillator cycles, 64 << select
  // ----------------------------------------------------------------------
  localparam logic [9:0] SETTLE_MIN_CYC = 10'h040;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_IDLE = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_WAKE = 3'b100,
    MODE_SETTLE = 3'b101
  } mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic oscEnable;
    logic coreClkEn;
    logic periphClkEn;
    logic regulatorOn;
    logic isrVector;
    logic [7:0] isrLine;
    logic skipIsr;
  } core_ctl_t;

endpackage : pwr_wake_pkg

// ===== src/power_mode_wakeup_ctrl.sv
// power-mode and wake-up controller: idle, stop and sleep entry and exit,
// wake mask, regulator settle delay and oscillator / clock gating
// assumes core_clk is the always-on oscillator model and that the core
// honours coreClkEn as a level and isrVector and skipIsr as pulses on this clock
`timescale 1ns/10ps
`default_nettype none

module power_mode_wakeup_ctrl #(
  parameter logic [7:0] STOP_WAKE_OK = 8'hdf  // lines with no clock of own
) (
  input wire logic core_clk,                 // oscillator-derived clock
  input wire logic arst_n,                   // async reset, active low
  input wire pwr_wake_pkg::apb_req_t apbReq, // apb request group
  output pwr_wake_pkg::apb_rsp_t apbRsp,     // apb answer group
  input wire logic [7:0] wakeSrc,            // raw lines, async
  input wire logic [7:0] intEnable,          // per-line interrupt enables
  input wire logic globalIntEn,              // core global enable
  output pwr_wake_pkg::core_ctl_t coreCtl,   // clock, supply, vector
  output logic irq                           // level interrupt
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    pwr_wake_pkg::mode_t mode;
    logic [2:0] modeBits;
    logic [7:0] wakeMask;
    logic [1:0] settleSel;
    logic [9:0] cnt;
    logic [3:0] irqStatus;
    logic [3:0] irqMask;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prevLvl;
    logic [7:0] pendLine;
    logic sleepWake;
    pwr_wake_pkg::apb_rsp_t rsp;
    pwr_wake_pkg::core_ctl_t ctl;
    logic irq;
  } state_t;

  localparam state_t STATE_RST = '{
    mode: pwr_wake_pkg::MODE_SETTLE,
    modeBits: pwr_wake_pkg::PCTL_RST,
    wakeMask: pwr_wake_pkg::WAKE_MASK_RST,
    settleSel: pwr_wake_pkg::SETTLE_SEL_RST,
    cnt: (pwr_wake_pkg::SETTLE_MIN_CYC << pwr_wake_pkg::SETTLE_SEL_RST)
         - 10'h001,
    irqStatus: 4'h0,
    irqMask: pwr_wake_pkg::IRQ_MASK_RST,
    // idle levels, so no false asserting edge follows reset
    sync1: pwr_wake_pkg::PIN_ACTIVE_LOW,
    sync2: pwr_wake_pkg::PIN_ACTIVE_LOW,
    prevLvl: 8'h00,
    pendLine: 8'h00,
    sleepWake: 1'b0,
    rsp: '{pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0},
    ctl: '{oscEnable: 1'b1, coreClkEn: 1'b0, periphClkEn: 1'b0,
           regulatorOn: 1'b1, isrVector: 1'b0, isrLine: 8'h00,
           skipIsr: 1'b0},
    irq: 1'b0
  };

  state_t s;
  state_t next_s;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // settle length in oscillator cycles minus one, for the down counter
  function automatic logic [9:0] settleLast(input logic [1:0] sel);
    settleLast = (pwr_wake_pkg::SETTLE_MIN_CYC << sel) - 10'h001;
  endfunction : settleLast

  // lowest-numbered line wins when several fire together
  function automatic logic [7:0] firstLine(input logic [7:0] v);
    firstLine = v & (~v + 8'h01);
  endfunction : firstLine

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [9:0] idx;
    logic access;
    logic commit;
    logic [7:0] asserted;
    logic [7:0] rising;
    logic [7:0] idleWake;
    logic [7:0] stopWake;
    logic [3:0] events;
    logic [31:0] rdVal;
    logic hit;
    idx = apbReq.paddr[pwr_wake_pkg::ADDR_W-1:2];
    access = apbReq.psel && apbReq.penable;
    commit = access && s.rsp.pready;
    events = 4'h0;
    rdVal = 32'h0000_0000;
    hit = 1'b1;
    next_s = s;

    // two-flop synchroniser on the async wake lines
    next_s.sync1 = wakeSrc;
    next_s.sync2 = s.sync1;
    // pins assert low, peripheral flags assert high
    asserted = s.sync2 ^ pwr_wake_pkg::PIN_ACTIVE_LOW;
    next_s.prevLvl = asserted;
    // only the asserting edge counts, level-triggered or not
    rising = asserted & ~s.prevLvl & pwr_wake_pkg::WAKE_LINE_IMPL;
    // idle: any enabled interrupt from still-running peripherals
    idleWake = rising & intEnable;
    // stop: enable and mask both needed, clocked sources excluded
    stopWake = rising & intEnable & s.wakeMask & STOP_WAKE_OK;

    // one-cycle pulses default low
    next_s.ctl.isrVector = 1'b0;
    next_s.ctl.skipIsr = 1'b0;

    // apb read decode
    unique case (idx)
      pwr_wake_pkg::PWR_CTRL_IDX: rdVal = 32'h0000_0000;
      pwr_wake_pkg::SETTLE_SEL_IDX:
        rdVal[pwr_wake_pkg::SETTLE_SEL_LSB +: 2] = s.settleSel;
      pwr_wake_pkg::WAKE_MASK_IDX: rdVal[7:0] = s.wakeMask;
      pwr_wake_pkg::IRQ_STATUS_IDX: rdVal[3:0] = s.irqStatus;
      pwr_wake_pkg::IRQ_MASK_IDX: rdVal[3:0] = s.irqMask;
      default: hit = 1'b0;
    endcase

    // answer one cycle into the access phase, then drop
    if (access && !s.rsp.pready) begin
      next_s.rsp.pready = 1'b1;
      next_s.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rdVal;
      next_s.rsp.pslverr = !hit;
    end else begin
      next_s.rsp.pready = 1'b0;
      next_s.rsp.prdata = 32'h0000_0000;
      next_s.rsp.pslverr = 1'b0;
    end

    // apb write takes effect at the completing edge only
    if (commit && apbReq.pwrite) begin
      unique case (idx)
        pwr_wake_pkg::PWR_CTRL_IDX: begin
          // mode bits are accepted only while running
          if (s.mode == pwr_wake_pkg::MODE_RUN) begin
            next_s.modeBits = apbReq.pwdata[2:0];
          end
        end
        pwr_wake_pkg::SETTLE_SEL_IDX:
          next_s.settleSel = apbReq.pwdata[pwr_wake_pkg::SETTLE_SEL_LSB +: 2];
        pwr_wake_pkg::WAKE_MASK_IDX: next_s.wakeMask = apbReq.pwdata[7:0];
        pwr_wake_pkg::IRQ_MASK_IDX: next_s.irqMask = apbReq.pwdata[3:0];
        default: ;
      endcase
    end

    // power mode sequencer
    unique case (s.mode)
      pwr_wake_pkg::MODE_RUN: begin
        if (s.modeBits[pwr_wake_pkg::PCTL_STOP_BIT]) begin
          // every clock off; oscillator shut on its own last edge
          next_s.ctl.coreClkEn = 1'b0;
          next_s.ctl.periphClkEn = 1'b0;
          next_s.ctl.oscEnable = 1'b0;
          if (s.modeBits[pwr_wake_pkg::PCTL_SLEEP_BIT]) begin
            // same logic as stop, main regulator also off
            next_s.ctl.regulatorOn = 1'b0;
            next_s.mode = pwr_wake_pkg::MODE_SLEEP;
          end else begin
            next_s.mode = pwr_wake_pkg::MODE_STOP;
          end
        end else if (s.modeBits[pwr_wake_pkg::PCTL_IDLE_BIT]) begin
          // core gated, external peripherals keep their clock
          next_s.ctl.coreClkEn = 1'b0;
          next_s.ctl.periphClkEn = 1'b1;
          next_s.ctl.oscEnable = 1'b1;
          next_s.mode = pwr_wake_pkg::MODE_IDLE;
        end
      end
      pwr_wake_pkg::MODE_IDLE: begin
        if (idleWake != 8'h00) begin
          next_s.pendLine = firstLine(idleWake);
          next_s.modeBits[pwr_wake_pkg::PCTL_IDLE_BIT] = 1'b0;
          next_s.ctl.coreClkEn = 1'b1;
          next_s.ctl.isrVector = globalIntEn;
          next_s.ctl.isrLine = firstLine(idleWake);
          next_s.ctl.skipIsr = !globalIntEn;
          events[pwr_wake_pkg::ST_IDLE_WAKE] = 1'b1;
          next_s.mode = pwr_wake_pkg::MODE_RUN;
        end
      end
      pwr_wake_pkg::MODE_STOP, pwr_wake_pkg::MODE_SLEEP: begin
        if (stopWake != 8'h00) begin
          // event restarts the oscillator first
          next_s.pendLine = firstLine(stopWake);
          next_s.ctl.oscEnable = 1'b1;
          next_s.sleepWake = (s.mode == pwr_wake_pkg::MODE_SLEEP);
          if (s.mode == pwr_wake_pkg::MODE_SLEEP) begin
            // regulator back on, wait for it before the core runs
            next_s.ctl.regulatorOn = 1'b1;
            next_s.cnt = settleLast(s.settleSel);
            next_s.mode = pwr_wake_pkg::MODE_SETTLE;
          end else begin
            next_s.mode = pwr_wake_pkg::MODE_WAKE;
          end
        end
      end
      pwr_wake_pkg::MODE_SETTLE: begin
        if (s.cnt == 10'h000) begin
          events[pwr_wake_pkg::ST_SETTLED] = 1'b1;
          next_s.mode = pwr_wake_pkg::MODE_WAKE;
        end else begin
          next_s.cnt = s.cnt - 10'h001;
        end
      end
      pwr_wake_pkg::MODE_WAKE: begin
        // first oscillator edge: clocks back, mode bits cleared
        next_s.ctl.coreClkEn = 1'b1;
        next_s.ctl.periphClkEn = 1'b1;
        next_s.modeBits = pwr_wake_pkg::PCTL_RST;
        next_s.ctl.isrLine = s.pendLine;
        // after reset there is no line to serve
        if (s.pendLine != 8'h00) begin
          next_s.ctl.isrVector = globalIntEn;
          next_s.ctl.skipIsr = !globalIntEn;
          if (s.sleepWake) begin
            events[pwr_wake_pkg::ST_SLEEP_WAKE] = 1'b1;
          end else begin
            events[pwr_wake_pkg::ST_STOP_WAKE] = 1'b1;
          end
        end
        next_s.pendLine = 8'h00;
        next_s.sleepWake = 1'b0;
        next_s.mode = pwr_wake_pkg::MODE_RUN;
      end
      default: begin
        // illegal code: fall back to running with clocks on
        next_s.mode = pwr_wake_pkg::MODE_RUN;
        next_s.ctl.oscEnable = 1'b1;
        next_s.ctl.coreClkEn = 1'b1;
        next_s.ctl.periphClkEn = 1'b1;
        next_s.ctl.regulatorOn = 1'b1;
      end
    endcase

    // sticky status: read clears, a same-cycle event still wins
    if (commit && !apbReq.pwrite && idx == pwr_wake_pkg::IRQ_STATUS_IDX) begin
      next_s.irqStatus = events;
    end else begin
      next_s.irqStatus = s.irqStatus | events;
    end
    next_s.irq = |(next_s.irqStatus & next_s.irqMask);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // whole state in one register; reset loads constants only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign apbRsp = s.rsp;
  assign coreCtl = s.ctl;
  assign irq = s.irq;

endmodule : power_mode_wakeup_ctrl

`default_nettype wire

// ===== test/power_mode_wakeup_ctrl_asserts.sv
// checker for the power-mode and wake-up controller ports
// assumes one clock domain, bound onto every controller instance
`timescale 1ns/10ps
`default_nettype none

module power_mode_wakeup_ctrl_asserts (
  input wire logic core_clk, // controller clock
  input wire logic arst_n, // async reset, active low
  input wire pwr_wake_pkg::apb_req_t apbReq, // bus request
  input wire pwr_wake_pkg::apb_rsp_t apbRsp, // bus answer
  input wire pwr_wake_pkg::core_ctl_t coreCtl // gates and vector
);
  // ------------------------------------------------------------------
  // one clock, one reset for every property
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // bus handshake steps
  sequence s_access;
    apbReq.psel && apbReq.penable && !apbRsp.pready;
  endsequence
  sequence s_answer;
    apbRsp.pready ##1 !apbRsp.pready;
  endsequence
  // core clock held off for the first 8 cycles after the regulator turns on
  sequence s_gated;
    !coreCtl.coreClkEn [*8];
  endsequence

  a_ready_one_cycle: assert property (s_access |=> s_answer)
    else $error("bus answer late or not a single pulse");
  a_error_no_data: assert property (apbRsp.pslverr |-> apbRsp.prdata == 0)
    else $error("read data with slave error");
  a_clk_needs_osc: assert property (!coreCtl.oscEnable |->
    !coreCtl.coreClkEn && !coreCtl.periphClkEn)
    else $error("clock gate open with oscillator off");
  a_clk_needs_reg: assert property (coreCtl.coreClkEn |->
    coreCtl.regulatorOn)
    else $error("core clock on with regulator off");
  a_settle_hold: assert property ($rose(coreCtl.regulatorOn) |-> s_gated)
    else $error("clock resumed before regulator settle");
  a_vector_pulse: assert property (coreCtl.isrVector |=>
    !coreCtl.isrVector)
    else $error("vector pulse longer than one cycle");
  a_vector_clocked: assert property (coreCtl.isrVector |->
    coreCtl.coreClkEn && coreCtl.oscEnable)
    else $error("vector issued with clock stopped");
  a_vector_skip_excl: assert property (!(coreCtl.isrVector &&
    coreCtl.skipIsr))
    else $error("vector and skip together");
  a_line_one_hot: assert property ((coreCtl.isrVector ||
    coreCtl.skipIsr) |-> $onehot(coreCtl.isrLine))
    else $error("waking line not one-hot");
endmodule : power_mode_wakeup_ctrl_asserts

bind power_mode_wakeup_ctrl power_mode_wakeup_ctrl_asserts chk_u (
  .core_clk(core_clk), .arst_n(arst_n), .apbReq(apbReq),
  .apbRsp(apbRsp), .coreCtl(coreCtl));

`default_nettype wire

// ===== test/power_mode_wakeup_ctrl_test.sv
// self-checking bench for the power-mode and wake-up controller
// assumes the package is compiled first and the checker is bound
`timescale 1ns/10ps
`default_nettype none

module power_mode_wakeup_ctrl_test;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  pwr_wake_pkg::apb_req_t apbReq = '0;
  pwr_wake_pkg::apb_rsp_t apbRsp;
  logic [7:0] wakeSrc = 8'h03;
  logic [7:0] intEnable = 8'hff;
  logic globalIntEn = 1'b1;
  pwr_wake_pkg::core_ctl_t coreCtl;
  logic irq;
  int err_total = 0;
  int comparisons = 0;
  int n;
  logic [31:0] seed = 32'h42;
  logic [31:0] rd;
  logic se;
  logic [7:0] wm;

  // 125 MHz
  always #4 core_clk = ~core_clk;

  // line 3 counted as clocked so a stop refusal can be seen
  power_mode_wakeup_ctrl #(.STOP_WAKE_OK(8'hd7)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .apbReq(apbReq),
    .apbRsp(apbRsp), .wakeSrc(wakeSrc), .intEnable(intEnable),
    .globalIntEn(globalIntEn), .coreCtl(coreCtl), .irq(irq));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one bus cycle; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] wd);
    @(posedge core_clk);
    apbReq <= {1'b1, 1'b0, wr, idx, 2'b00, wd};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    @(posedge core_clk);
    for (n = 0; n < 20 && apbRsp.pready !== 1'b1; n++) @(posedge core_clk);
    rd = apbRsp.prdata;
    se = apbRsp.pslverr;
    apbReq <= '0;
  endtask : apb

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------------
  // main sequence; model state is wm and the expected status words
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    for (n = 0; n < 600 && coreCtl.coreClkEn !== 1'b1; n++)
      @(posedge core_clk);
    check(n >= 256 && n <= 260, 1);
    apb(0, pwr_wake_pkg::WAKE_MASK_IDX, 0);
    check(rd, 32'hff);
    apb(0, pwr_wake_pkg::PWR_CTRL_IDX, 0);
    check(rd, 0);
    apb(0, pwr_wake_pkg::IRQ_STATUS_IDX, 0);
    check(rd, 32'h8);
    apb(0, pwr_wake_pkg::IRQ_STATUS_IDX, 0);
    check(rd, 0);
    apb(1, 10'h200, 32'h1);
    check({rd[30:0], se}, 32'h1);
    apb(1, pwr_wake_pkg::IRQ_MASK_IDX, 32'h2);
    // random mask, line 7 kept on and line 2 kept off
    seed = xs(seed);
    // pin 0 kept on as well: the sleep scenario wakes on it
    wm = (seed[7:0] | 8'ha1) & 8'hfb;
    apb(1, pwr_wake_pkg::WAKE_MASK_IDX, {24'h0, wm});
    apb(0, pwr_wake_pkg::WAKE_MASK_IDX, 0);
    check(rd, {24'h0, wm});
    // stop: line 4 already high at entry must not wake
    wakeSrc <= 8'h13;
    // core_clk already is the oscillator model, other sources idle
    apb(1, pwr_wake_pkg::PWR_CTRL_IDX, 32'h2);
    repeat (2) @(posedge core_clk);
    check({coreCtl.oscEnable, coreCtl.coreClkEn, coreCtl.periphClkEn,
           coreCtl.regulatorOn}, 4'b0001);
    wakeSrc <= 8'h1f;
    repeat (20) @(posedge core_clk);
    check(coreCtl.oscEnable, 0);
    wakeSrc <= 8'h9f;
    for (n = 0; n < 20 && coreCtl.isrVector !== 1'b1; n++)
      @(posedge core_clk);
    check(n < 8, 1);
    check(coreCtl.isrLine, 8'h80);
    check({coreCtl.oscEnable, coreCtl.coreClkEn}, 2'b11);
    check(irq, 1);
    apb(0, pwr_wake_pkg::IRQ_STATUS_IDX, 0);
    check(rd, 32'h2);
    repeat (2) @(posedge core_clk);
    check(irq, 0);
    // sleep with shortest settle and global enable off
    wakeSrc <= 8'h03;
    globalIntEn <= 1'b0;
    apb(1, pwr_wake_pkg::SETTLE_SEL_IDX, 0);
    apb(1, pwr_wake_pkg::PWR_CTRL_IDX, 32'h6);
    repeat (2) @(posedge core_clk);
    check({coreCtl.oscEnable, coreCtl.regulatorOn}, 2'b00);
    wakeSrc <= 8'h02;
    for (n = 0; n < 20 && coreCtl.oscEnable !== 1'b1; n++)
      @(posedge core_clk);
    for (n = 0; n < 600 && coreCtl.coreClkEn !== 1'b1; n++)
      @(posedge core_clk);
    check(n >= 64 && n <= 68, 1);
    check(coreCtl.skipIsr, 1);
    // software idles 20 us after the regulator settle count and wake
    repeat (2500) @(posedge core_clk);
    apb(0, pwr_wake_pkg::IRQ_STATUS_IDX, 0);
    check(rd, 32'hc);
    // idle: disabled line 2 ignored, line 4 wakes
    globalIntEn <= 1'b1;
    intEnable <= 8'hfb;
    wakeSrc <= 8'h03;
    apb(1, pwr_wake_pkg::PWR_CTRL_IDX, 32'h1);
    repeat (2) @(posedge core_clk);
    check({coreCtl.oscEnable, coreCtl.coreClkEn,
           coreCtl.periphClkEn}, 3'b101);
    wakeSrc <= 8'h07;
    repeat (10) @(posedge core_clk);
    check(coreCtl.coreClkEn, 0);
    wakeSrc <= 8'h17;
    for (n = 0; n < 20 && coreCtl.isrVector !== 1'b1; n++)
      @(posedge core_clk);
    check(coreCtl.isrLine, 8'h10);
    apb(0, pwr_wake_pkg::IRQ_STATUS_IDX, 0);
    check(rd, 32'h1);
    report_and_stop();
  end

  // watchdog: the sequence needs about 3000 cycles
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule : power_mode_wakeup_ctrl_test

`default_nettype wire
